// ===== inc/eeprom_host_pkg.sv
// constants for the parallel eeprom page-write host controller
// assumes a 50 MHz system clock and a byte-wide eeprom on plain pins
package eeprom_host_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int COL_W = 6;
  localparam int PAGE_BYTES = 64;
  localparam int ROW_LSB = 6;
  // minimum store strobe low time, ns
  localparam int STORE_STROBE_MIN_PULSE_NS = 150;
  localparam int STROBE_CYC = (STORE_STROBE_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // address setup before strobe, ns
  localparam int ADDR_SETUP_NS = 10;
  localparam int SETUP_CYC = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // read access time, ns
  localparam int READ_ACCESS_NS = 200;
  localparam int READ_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // strobe high to output released, ns
  localparam int FLOAT_NS = 60;
  localparam int FLOAT_CYC = (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // least byte load spacing and longest safe load window, ns
  localparam int PAGE_LOAD_WINDOW_MIN_NS = 200;
  localparam int GAP_CYC = (PAGE_LOAD_WINDOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAGE_LOAD_WINDOW_MAX_NS = 200000;
  localparam int WINDOW_CYC = PAGE_LOAD_WINDOW_MAX_NS / CLK_PERIOD_NS;
  // last byte loaded to polling, ns
  localparam int POLL_AFTER_LOAD_DELAY_NS = 200;
  localparam int POLL_CYC = (POLL_AFTER_LOAD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // internal write time, ms
  localparam int WRITE_TIME_MS = 10;
  localparam int WRITE_CYC = WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CNT_W = 20;
  localparam logic [7:0] DATA_RST = 8'h00;
endpackage : eeprom_host_pkg

// ===== hdl/cycle_timer.sv
// down counter that raises done once a loaded cycle count has run out
// assumes load is a one-cycle pulse on clk
`timescale 1ns/1ps
module cycle_timer
  import eeprom_host_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic load,
  input wire logic [CNT_W-1:0] count,
  output logic done
);
  logic [CNT_W-1:0] cnt_ff;
  assign done = (cnt_ff == '0);
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      cnt_ff <= '0;
    else if (load)
      cnt_ff <= count;
    else if (!done)
      cnt_ff <= cnt_ff - 1'b1;
  end
endmodule : cycle_timer

// ===== hdl/eeprom_host.sv
// host controller driving a byte-wide page-write eeprom through its pins
// assumes dataIn is the eeprom data bus as seen on the board, asynchronous
// Functional notes
// - host keeps store strobe high all read, address stable before chip select
// - write starts with select low, output drive high, address valid, then store low
// - host holds store strobe low at least the minimum pulse time
// - host may stretch a load by holding the strobe low
// - host polls until last byte reads back uninverted
// - polling read uses ordinary read strobes and timing
`timescale 1ns/1ps
module eeprom_host
  import eeprom_host_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic readReq,
  input wire logic writeReq,
  input wire logic lastByte,
  input wire logic [ADDR_W-1:0] reqAddr,
  input wire logic [DATA_W-1:0] reqData,
  output logic reqReady,
  output logic [DATA_W-1:0] rdData,
  output logic rdValid,
  output logic writeDone,
  output logic [ADDR_W-1:0] address,
  output logic chipSelect_b,
  output logic outputDrive_b,
  output logic storeStrobe_b,
  input wire logic [DATA_W-1:0] dataIn,
  output logic [DATA_W-1:0] dataOut,
  output logic dataOe
);
  typedef enum logic [3:0] {
    IDLE, RD_SETUP, RD_ACCESS, RD_FLOAT, WR_SETUP, WR_PULSE, WR_GAP,
    POLL_WAIT, POLL_SETUP, POLL_ACCESS, POLL_FLOAT
  } state_t;

  state_t state_ff, nxt_state;
  logic [DATA_W-1:0] syncA_ff, syncB_ff;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [DATA_W-1:0] wdata_ff, nxt_wdata, rdData_ff, nxt_rdData;
  logic [ADDR_W-COL_W-1:0] row_ff, nxt_row;
  logic [6:0] bytes_ff, nxt_bytes;
  logic rdValid_ff, nxt_rdValid, done_ff, nxt_done, pageOpen_ff, nxt_pageOpen;
  logic tmrLoad, tmrDone;
  logic [CNT_W-1:0] tmrCount;

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n);
  endfunction : cyc

  // wait between strobes also bounds the load window
  cycle_timer u_timer (
    .clk(clk),
    .rst_b(rst_b),
    .load(tmrLoad),
    .count(tmrCount),
    .done(tmrDone)
  );

  wire sameRow = (reqAddr[ADDR_W-1:ROW_LSB] == row_ff);
  wire pageFull = (bytes_ff == 7'(PAGE_BYTES));
  wire canLoad = !pageOpen_ff || (sameRow && !pageFull);
  // compare the byte captured at the end of the access, not the floating bus
  wire pollMatch = (rdData_ff == wdata_ff);

  assign reqReady = (state_ff == IDLE) && (!writeReq || canLoad);
  assign rdData = rdData_ff;
  assign rdValid = rdValid_ff;
  assign writeDone = done_ff;
  assign address = addr_ff;
  assign dataOut = wdata_ff;
  // write pattern only in WR_SETUP and WR_PULSE, read pattern in the access states, else inhibit
  wire inWrite = (state_ff == WR_SETUP) || (state_ff == WR_PULSE);
  wire inRead = (state_ff == RD_ACCESS) || (state_ff == POLL_ACCESS);
  assign chipSelect_b = !(inWrite || inRead);
  assign outputDrive_b = !inRead;
  assign storeStrobe_b = !(state_ff == WR_PULSE);
  assign dataOe = inWrite;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_rdData = rdData_ff;
    nxt_row = row_ff;
    nxt_bytes = bytes_ff;
    nxt_rdValid = 1'b0;
    nxt_done = 1'b0;
    nxt_pageOpen = pageOpen_ff;
    tmrLoad = 1'b0;
    tmrCount = cyc(SETUP_CYC);
    unique case (state_ff)
      IDLE:
      begin
        if (writeReq && canLoad)
        begin
          nxt_addr = reqAddr;
          nxt_wdata = reqData;
          if (!pageOpen_ff)
            nxt_row = reqAddr[ADDR_W-1:ROW_LSB];
          nxt_pageOpen = 1'b1;
          nxt_bytes = bytes_ff + 7'd1;
          tmrLoad = 1'b1;
          nxt_state = WR_SETUP;
        end
        else if (readReq && !pageOpen_ff)
        begin
          nxt_addr = reqAddr;
          tmrLoad = 1'b1;
          nxt_state = RD_SETUP;
        end
        else if (pageOpen_ff && (lastByte || pageFull || tmrDone))
        begin
          // close page before the device window can expire
          tmrLoad = 1'b1;
          tmrCount = cyc(POLL_CYC);
          nxt_state = POLL_WAIT;
        end
      end
      RD_SETUP, POLL_SETUP:
        if (tmrDone)
        begin
          tmrLoad = 1'b1;
          tmrCount = cyc(READ_CYC);
          nxt_state = (state_ff == RD_SETUP) ? RD_ACCESS : POLL_ACCESS;
        end
      RD_ACCESS, POLL_ACCESS:
        if (tmrDone)
        begin
          nxt_rdData = syncB_ff;
          tmrLoad = 1'b1;
          tmrCount = cyc(FLOAT_CYC);
          nxt_state = (state_ff == RD_ACCESS) ? RD_FLOAT : POLL_FLOAT;
        end
      RD_FLOAT:
        if (tmrDone)
        begin
          nxt_rdValid = 1'b1;
          nxt_state = IDLE;
        end
      WR_SETUP:
        if (tmrDone)
        begin
          tmrLoad = 1'b1;
          tmrCount = cyc(STROBE_CYC);
          nxt_state = WR_PULSE;
        end
      WR_PULSE:
        if (tmrDone)
        begin
          tmrLoad = 1'b1;
          tmrCount = cyc(GAP_CYC);
          nxt_state = WR_GAP;
        end
      WR_GAP:
        if (tmrDone)
        begin
          // next byte must come within the load window
          tmrLoad = 1'b1;
          tmrCount = cyc(WINDOW_CYC - GAP_CYC - READ_CYC);
          nxt_state = IDLE;
        end
      POLL_WAIT:
        if (tmrDone)
        begin
          tmrLoad = 1'b1;
          nxt_state = POLL_SETUP;
        end
      POLL_FLOAT:
        if (tmrDone)
        begin
          // inverse data means still busy, keep polling
          tmrLoad = 1'b1;
          if (pollMatch)
          begin
            nxt_done = 1'b1;
            nxt_pageOpen = 1'b0;
            nxt_bytes = 7'd0;
            nxt_state = IDLE;
          end
          else
            nxt_state = POLL_SETUP;
        end
    endcase
  end

  always_ff @(posedge clk)
  begin
    syncA_ff <= dataIn;
    syncB_ff <= syncA_ff;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_ff <= IDLE;
      addr_ff <= '0;
      wdata_ff <= DATA_RST;
      rdData_ff <= DATA_RST;
      row_ff <= '0;
      bytes_ff <= '0;
      rdValid_ff <= 1'b0;
      done_ff <= 1'b0;
      pageOpen_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      rdData_ff <= nxt_rdData;
      row_ff <= nxt_row;
      bytes_ff <= nxt_bytes;
      rdValid_ff <= nxt_rdValid;
      done_ff <= nxt_done;
      pageOpen_ff <= nxt_pageOpen;
    end
  end
endmodule : eeprom_host

// ===== verif/eeprom_host_checker.sv
// pin assertions for the eeprom host
// assumes a bind onto eeprom_host
`timescale 1ns/1ps
module eeprom_host_checker
  import eeprom_host_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic writeReq,
  input wire logic reqReady,
  input wire logic rdValid,
  input wire logic writeDone,
  input wire logic [ADDR_W-1:0] address,
  input wire logic chipSelect_b,
  input wire logic outputDrive_b,
  input wire logic storeStrobe_b,
  input wire logic dataOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_wr; !storeStrobe_b |-> !chipSelect_b && outputDrive_b && dataOe; endproperty
  a_wr: assert property (p_wr) else $error("bad write strobes");
  property p_oe; dataOe |-> outputDrive_b; endproperty
  a_oe: assert property (p_oe) else $error("bus fight");
  property p_rd; !outputDrive_b |-> storeStrobe_b; endproperty
  a_rd: assert property (p_rd) else $error("store low in read");
  property p_pw; $fell(storeStrobe_b) |-> !storeStrobe_b [*8]; endproperty
  a_pw: assert property (p_pw) else $error("store pulse short");
  property p_ad; !storeStrobe_b && !$fell(storeStrobe_b) |-> $stable(address); endproperty
  a_ad: assert property (p_ad) else $error("address moved");
  property p_ra; $fell(outputDrive_b) |-> !outputDrive_b [*8]; endproperty
  a_ra: assert property (p_ra) else $error("read too short");
  property p_go; writeReq && reqReady |=> !chipSelect_b && outputDrive_b; endproperty
  a_go: assert property (p_go) else $error("write not started");
  property p_rv; rdValid |-> chipSelect_b && outputDrive_b; endproperty
  a_rv: assert property (p_rv) else $error("read still open");
  c_wd: cover property (writeDone);
  c_rv: cover property (rdValid);
  c_st: cover property ($fell(storeStrobe_b));
endmodule : eeprom_host_checker
bind eeprom_host eeprom_host_checker chk_i (.*);

// ===== verif/eeprom_model.sv
// eeprom device model: page load, load timer, internal write, polling
// assumes host strobes change just after clk edges
`timescale 1ns/1ps
module eeprom_model
  import eeprom_host_pkg::*;
#(parameter int WIN = 60, parameter int WR = 100)
(
  input wire logic clk,
  input wire logic [ADDR_W-1:0] address,
  input wire logic chipSelect_b,
  input wire logic outputDrive_b,
  input wire logic storeStrobe_b,
  input wire logic [DATA_W-1:0] dataOut,
  output logic [DATA_W-1:0] dataIn
);
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] lastWr = 8'h00, lastBus = 8'h00, dLat;
  logic [ADDR_W-1:0] aLat;
  logic [ADDR_W-COL_W-1:0] row;
  logic loading = 0, busy = 0, loadPrev = 0, wrLong = 0;
  int cnt = 0;
  wire wrSel = !chipSelect_b && outputDrive_b && !storeStrobe_b && !busy;
  wire rdSel = !chipSelect_b && !outputDrive_b && storeStrobe_b;
  wire logic [DATA_W-1:0] rdVal = (loading || busy) ? ~lastWr : mem[address];
  assign dataIn = rdSel ? rdVal : ~lastBus;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  always @(posedge clk)
  begin
    loadPrev <= wrSel;
    wrLong <= wrSel && loadPrev;
    if (rdSel) lastBus <= rdVal;
    if (wrSel)
    begin
      aLat <= address;
      dLat <= dataOut;
      cnt <= 0;
    end
    else if (loadPrev && wrLong)
    begin
      if (!loading) row <= aLat[ADDR_W-1:ROW_LSB];
      mem[{loading ? row : aLat[ADDR_W-1:ROW_LSB], aLat[COL_W-1:0]}] <= dLat;
      lastWr <= dLat;
      loading <= 1'b1;
      cnt <= 0;
    end
    else if (loading && cnt == WIN)
    begin
      loading <= 1'b0;
      busy <= 1'b1;
      cnt <= 0;
    end
    else if (busy && cnt == WR) busy <= 1'b0;
    else cnt <= cnt + 1;
  end
endmodule : eeprom_model

// ===== verif/tb_parallel_eeprom_page_write.sv
// testbench: host controller against the eeprom model
// assumes the checker binds itself
`timescale 1ns/1ps
module tb_parallel_eeprom_page_write
  import eeprom_host_pkg::*;
;
  logic clk = 0, rst_b = 0, readReq = 0, writeReq = 0, lastByte = 0;
  logic reqReady, rdValid, writeDone, chipSelect_b, outputDrive_b, storeStrobe_b, dataOe;
  logic [ADDR_W-1:0] reqAddr = 13'h0000, address;
  logic [DATA_W-1:0] reqData = 8'h00, rdData, dataIn, dataOut, v;
  int fail_count = 0, samples_checked = 0;
  initial forever #10 clk = ~clk;
  eeprom_host dut (.*);
  eeprom_model partner (.*);
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  task waitSig(input int sel, input int lim);
    int n;
    logic s;
    n = 0;
    s = 1'b0;
    // sample mid-cycle, then pass the edge at which the design acts on it
    while (s !== 1'b1 && n < lim)
    begin
      @(negedge clk);
      s = (sel == 0) ? reqReady : (sel == 1) ? rdValid : writeDone;
      @(posedge clk);
      n++;
    end
    if (s !== 1'b1)
    begin
      fail_count++;
      $display("unexpected at %0t: wait ran out", $time);
      wrap_up();
    end
    #1;
  endtask : waitSig
  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    #1;
    reqAddr = a;
    reqData = d;
    writeReq = 1'b1;
    waitSig(0, 300);
    writeReq = 1'b0;
  endtask : wr
  task rd(input logic [ADDR_W-1:0] a);
    reqAddr = a;
    readReq = 1'b1;
    waitSig(0, 300);
    readReq = 1'b0;
    waitSig(1, 100);
    v = rdData;
  endtask : rd
  task close;
    lastByte = 1'b1;
    waitSig(2, 5000);
    lastByte = 1'b0;
  endtask : close
  task t_blank;
    chk({chipSelect_b, outputDrive_b, storeStrobe_b, dataOe}, 4'hE);
    rd(13'h1FFF);
    chk(v, 8'hFF);
  endtask : t_blank
  task t_page;
    for (int i = 0; i < PAGE_BYTES - 1; i++) wr({7'h05, 6'(63 - i)}, 8'(3 * i + 1));
    waitSig(0, 300);
    reqAddr = 13'h0180;
    writeReq = 1'b1;
    #1 chk(reqReady, 1'b0);
    @(posedge clk);
    #1 writeReq = 1'b0;
    chk(chipSelect_b, 1'b1);
    wr(13'h0140, 8'hBE);
    close();
    rd(13'h017F);
    chk(v, 8'h01);
    rd(13'h0140);
    chk(v, 8'hBE);
    rd(13'h0154);
    chk(v, 8'h82);
  endtask : t_page
  task t_byte;
    wr(13'h1A05, 8'h5A);
    close();
    rd(13'h1A05);
    chk(v, 8'h5A);
  endtask : t_byte
  initial
  begin
    repeat (10) @(posedge clk);
    #1 rst_b = 1'b1;
    t_blank();
    t_page();
    t_byte();
    wrap_up();
  end
endmodule : tb_parallel_eeprom_page_write
